// *** pkg/dbg_access_map.svh ***
// offsets, field positions, reset values and codes of the access-layer
// registers; included by the package and by the register block.
// Functional notes
// - key state bit 5 reads 1 while user-row write key is active.
// - key state bit 4 shows memory-program key; clears when programming done.
// - key state bit 3 shows full-erase key; clears when erase completes.
// - writing 0x59 to reset request register raises system reset request.
// - writing any other value releases the system reset request.
// - reset request reads 1 in bit 0 while reset held, zeros above.
// - system reset request never resets this access logic.
// - clock select 0..3 gives 32/16/8/4 MHz; resets to 3.
// - writing 1 to control bit 1 starts user-row programming.
// - control bit 1 write ignored unless user-row write key active.
// - control bit 0 requests system clock; writing 0 withdraws it.
// - clock request set on interface enable, cleared on disable.
// - status bit 5 sticky while system in reset; cleared by status read.
// - status bit 4 reads 1 while system idle or deeper sleep.
// - status bit 3 shows memory programming may begin.
// - status bit 2 shows user-row programming may begin.
// - status bit 0 reads 1 while locked; resets to 1.
// - checksum field one-hot: 0 off, 1 busy, 2 pass, 4 fail.
// - registers reachable only from the debug link port.
`ifndef DBG_ACCESS_MAP_SVH
`define DBG_ACCESS_MAP_SVH
`define DA_ADDR_W 4
`define DA_OFS_KEY 4'h7
`define DA_OFS_SYSTEM_RESET_SIGNATURE 4'h8
`define DA_OFS_CLKCTL 4'h9
`define DA_OFS_SYSCTL 4'hA
`define DA_OFS_STATE 4'hB
`define DA_OFS_CRC 4'hC
`define DA_KEY_UROW 5
`define DA_KEY_NVM 4
`define DA_KEY_ERASE 3
`define DA_RST_SIGNATURE 8'h59
`define DA_CLKSEL_RST 2'h3
`define DA_CTL_DONE 1
`define DA_CTL_SYSTEM_CLOCK_REQUEST 0
`define DA_ST_RESET 5
`define DA_ST_SLEEP 4
`define DA_ST_NVM 3
`define DA_ST_UROW 2
`define DA_ST_LOCK 0
`define DA_CRC_OFF 3'h0
`define DA_CRC_BUSY 3'h1
`define DA_CRC_PASS 3'h2
`define DA_CRC_FAIL 3'h4
`define DA_SYS_SYNC_RST 10'h020
`endif

// *** pkg/dbg_access_pkg.sv ***
// types shared by the access-layer register block, the link model and the bench.
// assumes dbg_access_map.svh sits on the include path.
`include "dbg_access_map.svh"
package dbg_access_pkg;
  // one register access from the link's instruction decoder
  typedef struct packed {
    logic valid;
    logic write;
    logic [`DA_ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } acc_req_type;
  // levels arriving from the system domain
  typedef struct packed {
    logic in_reset;
    logic asleep;
    logic mem_prog_ready;
    logic user_row_ready;
    logic locked;
    logic mem_prog_done;
    logic erase_done;
    logic [2:0] crc;
  } sys_in_type;
endpackage

// *** rtl/level_sync.sv ***
// two-stage synchroniser for a bundle of independent levels.
// assumes each bit is a slow level from another domain.
`timescale 1ns/10ps
module level_sync #(
  parameter int WIDTH = 10,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  if (WIDTH < 1) begin : g_width_check
    $error("level_sync: WIDTH must be positive");
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule

// *** rtl/read_clear_flag.sv ***
// sticky flag: set by a level, cleared by a read strobe; set wins.
// assumes clear is a one-cycle strobe in the same clock domain.
`timescale 1ns/10ps
module read_clear_flag (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // control
  input wire logic flush_i,
  input wire logic set_i,
  input wire logic clear_i,
  output logic flag_o
);
  logic flag_q;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_q <= 1'b0;
    end else if (flush_i) begin
      flag_q <= 1'b0;
    end else if (set_i) begin
      flag_q <= 1'b1;
    end else if (clear_i) begin
      flag_q <= 1'b0;
    end
  end

  assign flag_o = flag_q;

  property p_set_wins;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    set_i && !flush_i |=> flag_q;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("sticky set lost");
endmodule

// *** rtl/debug_access_system_regs.sv ***
// access-layer register set of the single-wire debug link.
// assumes requests come only from the link's instruction decoder on
// ref_clk_i; key decode pulses share that clock, system levels do not.
`timescale 1ns/10ps
`include "dbg_access_map.svh"
module debug_access_system_regs (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // link state
  input wire logic link_enable_i,
  // register access from the link
  input wire dbg_access_pkg::acc_req_type acc_req_i,
  output logic [7:0] acc_rdata_o,
  output logic acc_ack_o,
  // key decoder pulses
  input wire logic user_row_write_key_set_i,
  input wire logic memory_program_key_set_i,
  input wire logic full_erase_key_set_i,
  // system domain levels
  input wire dbg_access_pkg::sys_in_type sys_i,
  // toward the system
  output logic system_reset_request_o,
  output logic [1:0] link_clock_select_o,
  output logic system_clock_request_o,
  output logic user_row_start_o
);
  dbg_access_pkg::sys_in_type sys_s;
  logic [9:0] sys_raw;
  logic en_q;
  logic soft_rst;
  logic wr;
  logic rd;
  logic rst_req_q;
  logic [1:0] clksel_q;
  logic system_clock_request_q;
  logic done_q;
  logic start_q;
  logic key_urow_q;
  logic key_nvm_q;
  logic key_erase_q;
  logic nvm_done_q;
  logic erase_done_q;
  logic [2:0] crc_q;
  logic [2:0] crc_seen_q;
  logic sys_reset_flag;
  logic [7:0] rdata_q;
  logic ack_q;

  function automatic logic hit(input logic [`DA_ADDR_W-1:0] a,
                               input logic [`DA_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic crc_legal(input logic [2:0] c);
    crc_legal = (c == `DA_CRC_OFF) || (c == `DA_CRC_BUSY) ||
                (c == `DA_CRC_PASS) || (c == `DA_CRC_FAIL);
  endfunction

  // only the link port reaches these registers
  assign wr = acc_req_i.valid && acc_req_i.write;
  assign rd = acc_req_i.valid && !acc_req_i.write;
  // disabled link resets every register except the checksum status and the live-level status bits 4..0
  assign soft_rst = !link_enable_i;

  assign sys_raw = sys_i;

  level_sync #(
    .WIDTH(10),
    .RESET_VAL(`DA_SYS_SYNC_RST)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .async_i(sys_raw),
    .sync_o(sys_s)
  );

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      en_q <= 1'b0;
      nvm_done_q <= 1'b0;
      erase_done_q <= 1'b0;
    end else begin
      en_q <= link_enable_i;
      nvm_done_q <= sys_s.mem_prog_done;
      erase_done_q <= sys_s.erase_done;
    end
  end

  // reset request register; its own reset never reaches this logic
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_req_q <= 1'b0;
    end else if (soft_rst) begin
      rst_req_q <= 1'b0;
    end else if (wr && hit(acc_req_i.addr, `DA_OFS_SYSTEM_RESET_SIGNATURE)) begin
      rst_req_q <= (acc_req_i.wdata == `DA_RST_SIGNATURE);
    end
  end

  // link clock select
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clksel_q <= `DA_CLKSEL_RST;
    end else if (soft_rst) begin
      clksel_q <= `DA_CLKSEL_RST;
    end else if (wr && hit(acc_req_i.addr, `DA_OFS_CLKCTL)) begin
      clksel_q <= acc_req_i.wdata[1:0];
    end
  end

  // system clock request
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      system_clock_request_q <= 1'b0;
    end else if (soft_rst) begin
      system_clock_request_q <= 1'b0;
    end else if (!en_q) begin
      system_clock_request_q <= 1'b1;
    end else if (wr && hit(acc_req_i.addr, `DA_OFS_SYSCTL)) begin
      system_clock_request_q <= acc_req_i.wdata[`DA_CTL_SYSTEM_CLOCK_REQUEST];
    end
  end

  // user-row done bit and its start pulse
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      done_q <= 1'b0;
      start_q <= 1'b0;
    end else if (soft_rst) begin
      done_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (wr && hit(acc_req_i.addr, `DA_OFS_SYSCTL) && key_urow_q) begin
        done_q <= acc_req_i.wdata[`DA_CTL_DONE];
        start_q <= acc_req_i.wdata[`DA_CTL_DONE];
      end
    end
  end

  // key flags; a decode pulse beats a same-cycle completion
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      key_urow_q <= 1'b0;
      key_nvm_q <= 1'b0;
      key_erase_q <= 1'b0;
    end else if (soft_rst) begin
      key_urow_q <= 1'b0;
      key_nvm_q <= 1'b0;
      key_erase_q <= 1'b0;
    end else begin
      if (user_row_write_key_set_i) begin
        key_urow_q <= 1'b1;
      end
      if (memory_program_key_set_i) begin
        key_nvm_q <= 1'b1;
      end else if (sys_s.mem_prog_done && !nvm_done_q) begin
        key_nvm_q <= 1'b0;
      end
      if (full_erase_key_set_i) begin
        key_erase_q <= 1'b1;
      end else if (sys_s.erase_done && !erase_done_q) begin
        key_erase_q <= 1'b0;
      end
    end
  end

  // checksum status: reserved codes and unsettled words never land
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      crc_seen_q <= `DA_CRC_OFF;
      crc_q <= `DA_CRC_OFF;
    end else begin
      crc_seen_q <= sys_s.crc;
      if (crc_legal(sys_s.crc) && sys_s.crc == crc_seen_q) begin
        crc_q <= sys_s.crc;
      end
    end
  end

  read_clear_flag u_reset_flag (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .flush_i(soft_rst),
    .set_i(sys_s.in_reset || rst_req_q),
    .clear_i(rd && hit(acc_req_i.addr, `DA_OFS_STATE)),
    .flag_o(sys_reset_flag)
  );

  // read data; unused bits stay zero
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= 8'h00;
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc_req_i.valid;
      if (rd) begin
        rdata_q <= 8'h00;
        if (hit(acc_req_i.addr, `DA_OFS_KEY)) begin
          rdata_q[`DA_KEY_UROW] <= key_urow_q;
          rdata_q[`DA_KEY_NVM] <= key_nvm_q;
          rdata_q[`DA_KEY_ERASE] <= key_erase_q;
        end
        if (hit(acc_req_i.addr, `DA_OFS_SYSTEM_RESET_SIGNATURE)) begin
          rdata_q[0] <= rst_req_q;
        end
        if (hit(acc_req_i.addr, `DA_OFS_CLKCTL)) begin
          rdata_q[1:0] <= clksel_q;
        end
        if (hit(acc_req_i.addr, `DA_OFS_SYSCTL)) begin
          rdata_q[`DA_CTL_DONE] <= done_q;
          rdata_q[`DA_CTL_SYSTEM_CLOCK_REQUEST] <= system_clock_request_q;
        end
        if (hit(acc_req_i.addr, `DA_OFS_STATE)) begin
          rdata_q[`DA_ST_RESET] <= sys_reset_flag;
          rdata_q[`DA_ST_SLEEP] <= sys_s.asleep;
          rdata_q[`DA_ST_NVM] <= sys_s.mem_prog_ready;
          rdata_q[`DA_ST_UROW] <= sys_s.user_row_ready;
          rdata_q[`DA_ST_LOCK] <= sys_s.locked;
        end
        if (hit(acc_req_i.addr, `DA_OFS_CRC)) begin
          rdata_q[2:0] <= crc_q;
        end
      end
    end
  end

  assign acc_rdata_o = rdata_q;
  assign acc_ack_o = ack_q;
  assign system_reset_request_o = rst_req_q;
  assign link_clock_select_o = clksel_q;
  assign system_clock_request_o = system_clock_request_q;
  assign user_row_start_o = start_q;

  property p_sig_sets;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    link_enable_i && wr && acc_req_i.addr == `DA_OFS_SYSTEM_RESET_SIGNATURE &&
    acc_req_i.wdata == 8'h59 |=> system_reset_request_o;
  endproperty
  a_sig_sets: assert property (p_sig_sets)
    else $error("signature did not raise reset");

  property p_other_clears;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    wr && acc_req_i.addr == `DA_OFS_SYSTEM_RESET_SIGNATURE &&
    acc_req_i.wdata != 8'h59 |=> !system_reset_request_o;
  endproperty
  a_other_clears: assert property (p_other_clears)
    else $error("reset request not released");

  property p_rd_reset;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    rd && acc_req_i.addr == `DA_OFS_SYSTEM_RESET_SIGNATURE |=>
    acc_ack_o && acc_rdata_o == {7'h00, $past(rst_req_q)};
  endproperty
  a_rd_reset: assert property (p_rd_reset)
    else $error("reset request readback wrong");

  property p_no_self_reset;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    rst_req_q && link_enable_i && !wr |=> $stable(clksel_q);
  endproperty
  a_no_self_reset: assert property (p_no_self_reset)
    else $error("system reset disturbed link registers");

  property p_clksel_default;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    !link_enable_i ##1 link_enable_i && !wr |-> clksel_q == 2'h3;
  endproperty
  a_clksel_default: assert property (p_clksel_default)
    else $error("clock select not 4 MHz after enable");

  property p_urow_start;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    link_enable_i && wr && acc_req_i.addr == `DA_OFS_SYSCTL &&
    acc_req_i.wdata[1] && key_urow_q |=> user_row_start_o ##1
    (!user_row_start_o || $past(wr));
  endproperty
  a_urow_start: assert property (p_urow_start)
    else $error("user-row start pulse wrong");

  property p_urow_locked;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    !key_urow_q |=> !user_row_start_o && $stable(done_q) || !link_enable_i;
  endproperty
  a_urow_locked: assert property (p_urow_locked)
    else $error("done bit written without key");

  property p_system_clock_request_auto;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    !link_enable_i ##1 link_enable_i |=> system_clock_request_o;
  endproperty
  a_system_clock_request_auto: assert property (p_system_clock_request_auto)
    else $error("clock request not set on enable");

  property p_reset_seen;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    rst_req_q && link_enable_i ##1 rst_req_q && link_enable_i |->
    sys_reset_flag [*2];
  endproperty
  a_reset_seen: assert property (p_reset_seen)
    else $error("held reset not visible in status");

  property p_crc_onehot;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    1'b1 |-> $onehot0(crc_q);
  endproperty
  a_crc_onehot: assert property (p_crc_onehot)
    else $error("checksum status not one-hot");
endmodule

// *** sim/link_master_model.sv ***
// debugger side of the access link: issues single-byte register accesses.
// assumes the bench calls access() and the block acks each request.
`timescale 1ns/10ps
module link_master_model (
  // clock
  input wire logic ref_clk_i,
  // register access toward the block
  output dbg_access_pkg::acc_req_type acc_req_o,
  input wire logic acc_ack_i,
  input wire logic [7:0] acc_rdata_i
);
  initial acc_req_o = '{valid: 1'b0, write: 1'b0, addr: 4'hF, wdata: 8'hA5};

  // one-cycle request pulse; released fields show inverted values
  task automatic access(input logic wr, input logic [3:0] a,
                        input logic [7:0] d);
    @(posedge ref_clk_i);
    #1;
    acc_req_o = '{valid: 1'b1, write: wr, addr: a, wdata: d};
    @(posedge ref_clk_i);
    #1;
    acc_req_o = '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
  endtask
endmodule

// *** sim/test_debug_access_system_regs.sv ***
// self-checking bench for the access-layer register set.
// assumes the link model drives requests and system levels come from here.
`timescale 1ns/10ps
module test_debug_access_system_regs;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic link_enable_i = 1'b1;
  logic urow_key = 1'b0;
  logic prog_key = 1'b0;
  logic erase_key = 1'b0;
  dbg_access_pkg::acc_req_type acc_req;
  dbg_access_pkg::sys_in_type sys_in = '0;
  logic [7:0] acc_rdata;
  logic acc_ack;
  logic rst_req;
  logic [1:0] clk_sel;
  logic clk_req;
  logic urow_start;
  int failures = 0;
  int check_count = 0;
  int starts = 0;
  integer seed = 32'hca9d;
  logic [7:0] r;
  logic [8:0] note;
  logic [8:0] notes[$];
  logic [2:0] crc_codes [4] = '{3'h0, 3'h1, 3'h2, 3'h4};

  always #2.5 ref_clk_i = ~ref_clk_i;

  debug_access_system_regs u_dut (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .link_enable_i(link_enable_i),
    .acc_req_i(acc_req), .acc_rdata_o(acc_rdata), .acc_ack_o(acc_ack),
    .user_row_write_key_set_i(urow_key),
    .memory_program_key_set_i(prog_key),
    .full_erase_key_set_i(erase_key), .sys_i(sys_in),
    .system_reset_request_o(rst_req), .link_clock_select_o(clk_sel),
    .system_clock_request_o(clk_req), .user_row_start_o(urow_start)
  );

  link_master_model u_link (
    .ref_clk_i(ref_clk_i), .acc_req_o(acc_req), .acc_ack_i(acc_ack),
    .acc_rdata_i(acc_rdata)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    notes.push_back(9'h000);
    u_link.access(1'b1, a, d);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    notes.push_back({1'b1, e});
    u_link.access(1'b0, a, 8'h00);
  endtask

  task automatic keys(input logic [2:0] k);
    @(posedge ref_clk_i);
    #1;
    {urow_key, prog_key, erase_key} = k;
    @(posedge ref_clk_i);
    #1;
    {urow_key, prog_key, erase_key} = 3'h0;
  endtask

  task automatic settle;
    repeat (4) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic close_out;
    if (failures == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // answer watcher: oldest note pairs with each ack
  always @(negedge ref_clk_i) begin
    if (acc_ack === 1'b1) begin
      if (notes.size() == 0) begin
        failures++;
        $display("unexpected at %0t: ack with no request", $time);
      end else begin
        note = notes.pop_front();
        if (note[8]) check(acc_rdata, note[7:0]);
      end
    end
    if (urow_start === 1'b1) starts++;
  end

  initial begin
    #20000;
    failures++;
    close_out();
  end

  initial begin
    sys_in.locked = 1'b1;
    repeat (4) @(posedge ref_clk_i);
    #1 nrst_i = 1'b1;
    settle();
    check({7'h00, clk_req}, 8'h01);
    check({6'h00, clk_sel}, 8'h03);
    rd(4'h7, 8'h00);
    rd(4'h8, 8'h00);
    rd(4'h9, 8'h03);
    rd(4'hB, 8'h01);
    rd(4'hC, 8'h00);
    rd(4'hF, 8'h00);
    wr(4'h8, 8'h59);
    check({7'h00, rst_req}, 8'h01);
    rd(4'h8, 8'h01);
    rd(4'h9, 8'h03);
    r = 8'($random(seed));
    if (r == 8'h59) r = 8'h58;
    wr(4'h8, r);
    check({7'h00, rst_req}, 8'h00);
    rd(4'h8, 8'h00);
    // faster rates assume highest brown-out level on the target
    for (int i = 0; i < 4; i++) begin
      r = 8'($random(seed));
      wr(4'h9, {r[7:2], 2'(i)});
      check({6'h00, clk_sel}, 8'(i));
      rd(4'h9, 8'(i));
    end
    wr(4'hA, 8'h00);
    check({7'h00, clk_req}, 8'h00);
    wr(4'hA, 8'h03);
    check({7'h00, clk_req}, 8'h01);
    rd(4'hA, 8'h01);
    settle();
    check(8'(starts), 8'h00);
    // user-row data assumed already in place before done bit
    keys(3'h4);
    wr(4'hA, 8'h03);
    settle();
    check(8'(starts), 8'h01);
    rd(4'hA, 8'h03);
    keys(3'h3);
    rd(4'h7, 8'h38);
    sys_in.mem_prog_done = 1'b1;
    settle();
    rd(4'h7, 8'h28);
    sys_in.erase_done = 1'b1;
    settle();
    rd(4'h7, 8'h20);
    sys_in.in_reset = 1'b1;
    sys_in.asleep = 1'b1;
    sys_in.mem_prog_ready = 1'b1;
    sys_in.user_row_ready = 1'b1;
    sys_in.locked = 1'b0;
    settle();
    sys_in.in_reset = 1'b0;
    settle();
    rd(4'hB, 8'h3C);
    rd(4'hB, 8'h1C);
    for (int j = 0; j < 4; j++) begin
      sys_in.crc = crc_codes[j];
      settle();
      rd(4'hC, {5'h00, crc_codes[j]});
    end
    sys_in.crc = 3'h3;
    settle();
    rd(4'hC, 8'h04);
    wr(4'h9, 8'h01);
    check({6'h00, clk_sel}, 8'h01);
    link_enable_i = 1'b0;
    settle();
    check({7'h00, clk_req}, 8'h00);
    link_enable_i = 1'b1;
    settle();
    check({7'h00, clk_req}, 8'h01);
    check({6'h00, clk_sel}, 8'h03);
    rd(4'h7, 8'h00);
    settle();
    check(8'(notes.size()), 8'h00);
    close_out();
  end
endmodule
